// File: core/sbw_defs.vh
`ifndef SBW_DEFS_VH
`define SBW_DEFS_VH

// organisations (data word width)
`define SBW_ORG_X8        8
`define SBW_ORG_X9        9
`define SBW_ORG_X18       18
`define SBW_ORG_X36       36

// widths
`define SBW_DATA_W        36
`define SBW_LANE_W        9
`define SBW_NIB_W         4
`define SBW_ADDR_W        6
`define SBW_SYNC_W        54

// reset values
`define SBW_Q_RST         36'h000000000
`define SBW_MASK_RST      36'h000000000
`define SBW_ADDR_RST      6'h00
`define SBW_EDGE_RST      4'hF

// write port states
`define SBW_WS_IDLE       2'h1
`define SBW_WS_SECOND     2'h2

// read port states
`define SBW_RS_IDLE       5'h01
`define SBW_RS_WAIT_K     5'h02
`define SBW_RS_WAIT_CN    5'h04
`define SBW_RS_WAIT_C     5'h08
`define SBW_RS_TAIL       5'h10

`endif

// File: core/sbw_burst_array.v
`timescale 1ns/100ps
`default_nettype none
`include "sbw_defs.vh"

// two banks: bank 0 holds burst word A+0, bank 1 holds A+1
module sbw_burst_array (
    input  wire                       clk,
    input  wire [`SBW_ADDR_W-1:0]     waddr,
    input  wire [`SBW_DATA_W-1:0]     wdata0,
    input  wire [`SBW_DATA_W-1:0]     wdata1,
    input  wire [`SBW_DATA_W-1:0]     wen0,
    input  wire [`SBW_DATA_W-1:0]     wen1,
    input  wire [`SBW_ADDR_W-1:0]     raddr,
    output wire [`SBW_DATA_W-1:0]     rdata0,
    output wire [`SBW_DATA_W-1:0]     rdata1
);
    localparam DEPTH = 1 << `SBW_ADDR_W;

    reg [`SBW_DATA_W-1:0] bank0 [0:DEPTH-1];
    reg [`SBW_DATA_W-1:0] bank1 [0:DEPTH-1];

    // per-bit merge: disabled bits keep their stored value
    always @(posedge clk) begin
        bank0[waddr] <= (bank0[waddr] & ~wen0) | (wdata0 & wen0);
        bank1[waddr] <= (bank1[waddr] & ~wen1) | (wdata1 & wen1);
    end

    assign rdata0 = bank0[raddr];
    assign rdata1 = bank1[raddr];
endmodule
`default_nettype wire

// File: core/sbw_byte_write_mask.v
`timescale 1ns/100ps
`default_nettype none
`include "sbw_defs.vh"

// Function
// - both selects low: whole word written
// - select0 only: lower lane written, upper kept
// - select1 only: upper lane written, lower kept
// - both selects high: no write that half
// - x9: single select governs bits 8..0
// - x36: four selects each enable nine bits
// - all selects high: no array update
// - selects sampled anew at each data edge
// - data captured on K and K-complement rises
// - reads launched on C pair, K in single mode
// - powers up deselected, outputs high impedance
// - burst order A+0 then A+1
// - t is start cycle, t+1/t+2 follow
// - read words at C-complement t+1, C t+2
module sbw_byte_write_mask #(
    parameter ORG = `SBW_ORG_X36
) (
    input  wire                       clk,
    input  wire                       rst,
    input  wire                       k,
    input  wire                       k_n,
    input  wire                       c,
    input  wire                       c_n,
    input  wire                       read_port_select_n,
    input  wire                       write_port_select_n,
    input  wire [1:0]                 half_byte_write_select_n,
    input  wire [3:0]                 lane_write_select_n,
    input  wire [`SBW_ADDR_W-1:0]     addr,
    input  wire [`SBW_DATA_W-1:0]     d,
    output reg  [`SBW_DATA_W-1:0]     q,
    output reg                        q_oe_n
);
    localparam WIDTH = ORG;

    // every pin goes through two flops; the clock pins are sampled
    // as levels and their rising edges found on the second stage
    wire [`SBW_SYNC_W-1:0] pins = {k, k_n, c, c_n, read_port_select_n,
        write_port_select_n, half_byte_write_select_n,
        lane_write_select_n, addr, d};

    reg [`SBW_SYNC_W-1:0] sync1;
    reg [`SBW_SYNC_W-1:0] sync2;
    reg [3:0]             clk_prev;

    always @(posedge clk) begin
        sync1 <= pins;
        sync2 <= sync1;
    end

    wire                   k_s   = sync2[53];
    wire                   kn_s  = sync2[52];
    wire                   c_s   = sync2[51];
    wire                   cn_s  = sync2[50];
    wire                   rps_s = sync2[49];
    wire                   wps_s = sync2[48];
    wire [1:0]             nws_s = sync2[47:46];
    wire [3:0]             bws_s = sync2[45:42];
    wire [`SBW_ADDR_W-1:0] a_s   = sync2[41:36];
    wire [`SBW_DATA_W-1:0] d_s   = sync2[35:0];

    // reset to all-high so a clock pin already high is no false edge
    always @(posedge clk) begin
        if (rst) begin
            clk_prev <= `SBW_EDGE_RST;
        end else begin
            clk_prev <= {k_s, kn_s, c_s, cn_s};
        end
    end

    wire k_rise  = k_s & ~clk_prev[3];
    wire kn_rise = kn_s & ~clk_prev[2];
    wire c_rise  = c_s & ~clk_prev[1];
    wire cn_rise = cn_s & ~clk_prev[0];

    // strap caught once, after reset release, then frozen
    reg strap_taken;
    reg single_clk;

    always @(posedge clk) begin
        if (rst) begin
            strap_taken <= 1'b0;
            single_clk  <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            single_clk  <= c_s & cn_s;
        end
    end

    wire oc_rise  = single_clk ? k_rise : c_rise;
    wire ocn_rise = single_clk ? kn_rise : cn_rise;

    // lane selects turned into a per-bit enable for the current edge
    wire [`SBW_DATA_W-1:0] bit_en;

    genvar i;
    generate
        for (i = 0; i < `SBW_DATA_W; i = i + 1) begin : g_lane
            if (i >= WIDTH) begin : g_unused
                assign bit_en[i] = 1'b0;
            end else if (ORG == `SBW_ORG_X8) begin : g_nib
                assign bit_en[i] = ~nws_s[i / `SBW_NIB_W];
            end else begin : g_byte
                assign bit_en[i] = ~bws_s[i / `SBW_LANE_W];
            end
        end
    endgenerate

    // write port
    reg [1:0]              wstate;
    reg [`SBW_DATA_W-1:0]  wword0;
    reg [`SBW_DATA_W-1:0]  wmask0;

    wire write_start = k_rise & ~wps_s;
    wire commit      = (wstate == `SBW_WS_SECOND) & kn_rise;

    always @(posedge clk) begin
        if (rst) begin
            wstate <= `SBW_WS_IDLE;
            wword0 <= `SBW_Q_RST;
            wmask0 <= `SBW_MASK_RST;
        end else begin
            case (wstate)
                `SBW_WS_IDLE: begin
                    if (write_start) begin
                        wword0 <= d_s;
                        wmask0 <= bit_en;
                        wstate <= `SBW_WS_SECOND;
                    end
                end
                `SBW_WS_SECOND: begin
                    if (commit) begin
                        wstate <= `SBW_WS_IDLE;
                    end
                end
                default: begin
                    wstate <= `SBW_WS_IDLE;
                end
            endcase
        end
    end

    // selects only reach the array inside a write's data portion
    wire [`SBW_DATA_W-1:0] wen0 = commit ? wmask0 : `SBW_MASK_RST;
    wire [`SBW_DATA_W-1:0] wen1 = commit ? bit_en : `SBW_MASK_RST;

    // read port
    reg [4:0]             rstate;
    reg [`SBW_ADDR_W-1:0] raddr_cur;
    reg [`SBW_ADDR_W-1:0] raddr_pend;
    reg                   rpend;
    reg                   rpend_k;
    wire [`SBW_DATA_W-1:0] rd0;
    wire [`SBW_DATA_W-1:0] rd1;

    wire read_start = k_rise & ~rps_s;
    wire finish = ((rstate == `SBW_RS_WAIT_C) & oc_rise) |
                  ((rstate == `SBW_RS_TAIL) & ocn_rise);

    sbw_burst_array u_array (
        .clk    (clk),
        .waddr  (a_s),
        .wdata0 (wword0),
        .wdata1 (d_s),
        .wen0   (wen0),
        .wen1   (wen1),
        .raddr  (raddr_cur),
        .rdata0 (rd0),
        .rdata1 (rd1)
    );

    always @(posedge clk) begin
        if (rst) begin
            rstate     <= `SBW_RS_IDLE;
            raddr_cur  <= `SBW_ADDR_RST;
            raddr_pend <= `SBW_ADDR_RST;
            rpend      <= 1'b0;
            rpend_k    <= 1'b0;
            q          <= `SBW_Q_RST;
            q_oe_n     <= 1'b1;
        end else begin
            // a read arriving mid-burst waits one slot; note whether
            // its t+1 K rise has already gone by
            if (read_start && rstate != `SBW_RS_IDLE &&
                !(finish && !rpend)) begin
                rpend      <= 1'b1;
                rpend_k    <= 1'b0;
                raddr_pend <= a_s;
            end else if (rpend && k_rise) begin
                rpend_k <= 1'b1;
            end
            case (rstate)
                `SBW_RS_IDLE: begin
                    if (read_start) begin
                        raddr_cur <= a_s;
                        rstate    <= `SBW_RS_WAIT_K;
                    end
                end
                `SBW_RS_WAIT_K: begin
                    if (k_rise) begin
                        rstate <= `SBW_RS_WAIT_CN;
                    end
                end
                `SBW_RS_WAIT_CN: begin
                    if (ocn_rise) begin
                        q      <= rd0;
                        q_oe_n <= 1'b0;
                        rstate <= `SBW_RS_WAIT_C;
                    end
                end
                `SBW_RS_WAIT_C: begin
                    if (oc_rise) begin
                        q <= rd1;
                    end
                end
                `SBW_RS_TAIL: begin
                    if (ocn_rise) begin
                        q_oe_n <= 1'b1;
                    end
                end
                default: begin
                    rstate <= `SBW_RS_IDLE;
                end
            endcase
            if (finish) begin
                if (rpend) begin
                    raddr_cur <= raddr_pend;
                    rpend     <= read_start;
                    // a K rise on this very edge is the queued read's t+1
                    rstate    <= (rpend_k | k_rise) ? `SBW_RS_WAIT_CN
                                                    : `SBW_RS_WAIT_K;
                end else if (read_start) begin
                    raddr_cur <= a_s;
                    rstate    <= `SBW_RS_WAIT_K;
                end else if (rstate == `SBW_RS_WAIT_C) begin
                    rstate <= `SBW_RS_TAIL;
                end else begin
                    rstate <= `SBW_RS_IDLE;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/sbw_mask_chk_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module sbw_mask_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        k,
    input wire logic        k_n,
    input wire logic        c,
    input wire logic        c_n,
    input wire logic        read_port_select_n,
    input wire logic [35:0] q,
    input wire logic        q_oe_n
);
    logic [3:0] pins_q;
    logic [3:0] ocnt;
    logic [3:0] pcnt;
    logic [6:0] icnt;
    // counters saturate so long idle stretches stay meaningful
    always @(posedge clk) begin
        pins_q <= {k, k_n, c, c_n};
        if (rst) begin
            ocnt <= 4'hF;
            pcnt <= 4'h0;
        end else begin
            if (|({k, k_n, c, c_n} & ~pins_q))
                ocnt <= 4'h0;
            else if (ocnt != 4'hF)
                ocnt <= ocnt + 4'h1;
            if ({k, k_n, c, c_n} != pins_q)
                pcnt <= 4'h0;
            else if (pcnt != 4'hF)
                pcnt <= pcnt + 4'h1;
        end
        if (rst || !read_port_select_n)
            icnt <= 7'h00;
        else if (icnt != 7'h7F)
            icnt <= icnt + 7'h01;
    end
    sequence s_drive;
        !q_oe_n [*6];
    endsequence
    sequence s_near_clk;
        (ocnt >= 4'h1) && (ocnt <= 4'h8);
    endsequence
    reset_quiet_a: assert property (@(posedge clk)
        rst |=> q_oe_n && q == 36'h000000000) else $error("busy after reset");
    reset_release_a: assert property (@(posedge clk)
        rst ##1 !rst |-> q_oe_n [*3]) else $error("drive after release");
    drive_hold_a: assert property (@(posedge clk) disable iff (rst)
        $fell(q_oe_n) |-> s_drive) else $error("drive window short");
    drive_start_a: assert property (@(posedge clk) disable iff (rst)
        $fell(q_oe_n) |-> s_near_clk) else $error("drive start off clock");
    drive_stop_a: assert property (@(posedge clk) disable iff (rst)
        $rose(q_oe_n) |-> s_near_clk) else $error("release off clock");
    word_change_a: assert property (@(posedge clk) disable iff (rst)
        $changed(q) && !q_oe_n |-> s_near_clk) else $error("q moved off clock");
    idle_tristate_a: assert property (@(posedge clk) disable iff (rst)
        icnt >= 7'd60 |-> q_oe_n) else $error("drive without read");
    quiet_pins_a: assert property (@(posedge clk) disable iff (rst)
        pcnt >= 4'h8 |-> $stable(q) && $stable(q_oe_n))
        else $error("output moved with clocks still");
endmodule
bind sbw_byte_write_mask sbw_mask_chk sbw_mask_chk_inst (
    .clk(clk), .rst(rst), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
    .read_port_select_n(read_port_select_n), .q(q), .q_oe_n(q_oe_n));
`default_nettype wire

// File: tb/sbw_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module sbw_ctrl_model (
    input wire logic         clk,
    input wire logic [35:0]  q,
    input wire logic         q_oe_n,
    output var logic         k,
    output var logic         k_n,
    output var logic         c,
    output var logic         c_n,
    output var logic         rps_n,
    output var logic         wps_n,
    output var logic [3:0]   sel,
    output var logic [5:0]   a,
    output var logic [35:0]  d
);
    logic [35:0] qa;
    logic [35:0] qb;
    logic        oa;
    // c low at power-on keeps the dual clock mode
    initial begin
        {k, k_n, c, c_n} = 4'h5;
        {rps_n, wps_n, sel, a, d} = '1;
    end
    task hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one K cycle; phases of 6 clk give 3 clk set-up and hold
    task cyc(input logic w, input logic r, input logic [5:0] ad,
             input logic [35:0] w0, input logic [3:0] s0,
             input logic [35:0] w1, input logic [3:0] s1);
        begin
            wps_n = ~w;
            rps_n = ~r;
            a = ad;
            d = w ? w0 : ~d;
            sel = s0;
            hold(2);
            qa = q;
            oa = q_oe_n;
            hold(1);
            {k, k_n, c, c_n} = 4'hA;
            hold(3);
            {wps_n, rps_n} = 2'h3;
            d = w ? w1 : ~d;
            sel = s1;
            hold(2);
            qb = q;
            hold(1);
            {k, k_n, c, c_n} = 4'h5;
            hold(3);
        end
    endtask
endmodule
`default_nettype wire

// File: tb/tb_sbw_byte_write_mask.sv
`timescale 1ns/100ps
`default_nettype none
module tb_sbw_byte_write_mask;
    logic clk, rst, k, k_n, c, c_n, rps_n, wps_n, q_oe_n;
    logic [3:0] sel;
    logic [5:0] a;
    logic [35:0] d, q;
    logic [35:0] m0[0:63], m1[0:63];
    int n_fail = 0, n_compared = 0, cycles = 0;
    sbw_byte_write_mask sbw_byte_write_mask_inst (.clk(clk), .rst(rst),
        .k(k), .k_n(k_n), .c(c), .c_n(c_n), .read_port_select_n(rps_n),
        .write_port_select_n(wps_n), .half_byte_write_select_n(sel[1:0]),
        .lane_write_select_n(sel), .addr(a), .d(d), .q(q), .q_oe_n(q_oe_n));
    sbw_ctrl_model ctl (.clk(clk), .q(q), .q_oe_n(q_oe_n), .k(k), .k_n(k_n),
        .c(c), .c_n(c_n), .rps_n(rps_n), .wps_n(wps_n), .sel(sel), .a(a),
        .d(d));
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    task chk_word(input logic [35:0] got, input logic [35:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_flag(input logic got, input logic exp);
        chk_word({35'h0, got}, {35'h0, exp});
    endtask
    function automatic logic [35:0] merge(input logic [35:0] o, w,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++)
            if (!s[i]) o[i*9 +: 9] = w[i*9 +: 9];
        return o;
    endfunction
    task wr(input logic [5:0] ad, input logic [35:0] w0, input logic [3:0] s0,
            input logic [35:0] w1, input logic [3:0] s1);
        ctl.cyc(1, 0, ad, w0, s0, w1, s1);
        m0[ad] = merge(m0[ad], w0, s0);
        m1[ad] = merge(m1[ad], w1, s1);
    endtask
    task rd_check(input logic [5:0] ad);
        ctl.cyc(0, 1, ad, '0, 4'hF, '0, 4'hF);
        repeat (2) ctl.cyc(0, 0, ad, '0, 4'hF, '0, 4'hF);
        chk_word(ctl.qa, m0[ad]);
        chk_word(ctl.qb, m1[ad]);
        chk_flag(ctl.oa, 1'b0);
        ctl.cyc(0, 0, ad, '0, 4'hF, '0, 4'hF);
        chk_flag(ctl.oa, 1'b1);
    endtask
    task t_reset;
        chk_flag(q_oe_n, 1'b1);
        chk_word(q, 36'h000000000);
        $display("test reset done");
    endtask
    task t_masks;
        logic [3:0] sp[0:5];
        sp = '{4'h0, 4'hE, 4'hD, 4'hB, 4'h7, 4'hF};
        wr(5, 36'h123456789, 4'h0, 36'hFEDCBA987, 4'h0);
        rd_check(5);
        for (int i = 0; i < 6; i++) begin
            wr(5, 36'hA5A5A5A5A ^ i, sp[i], 36'h5A5A5A5A5 + i, sp[5-i]);
            rd_check(5);
        end
        $display("test masks done");
    endtask
    task t_idle;
        ctl.cyc(0, 0, 5, 36'h0F0F0F0F0, 4'h0, 36'hF0F0F0F0F, 4'h0);
        ctl.cyc(0, 0, 5, 36'h333333333, 4'h0, 36'hCCCCCCCCC, 4'h0);
        chk_flag(ctl.oa, 1'b1);
        rd_check(5);
        $display("test idle done");
    endtask
    task t_b2b;
        wr(6, 36'h0000000FF, 4'h0, 36'hFF0000000, 4'h0);
        ctl.cyc(0, 1, 5, '0, 4'hF, '0, 4'hF);
        ctl.cyc(0, 1, 6, '0, 4'hF, '0, 4'hF);
        ctl.cyc(0, 0, 6, '0, 4'hF, '0, 4'hF);
        chk_word(ctl.qa, m0[5]);
        chk_word(ctl.qb, m1[5]);
        ctl.cyc(0, 0, 6, '0, 4'hF, '0, 4'hF);
        chk_flag(ctl.oa, 1'b0);
        chk_word(ctl.qa, m0[6]);
        chk_word(ctl.qb, m1[6]);
        ctl.cyc(0, 0, 6, '0, 4'hF, '0, 4'hF);
        chk_flag(ctl.oa, 1'b1);
        $display("test back to back done");
    endtask
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            end_of_test;
        end
    end
    initial begin
        rst = 1;
        repeat (16) @(negedge clk);
        t_reset;
        rst = 0;
        repeat (3) @(negedge clk);
        t_masks;
        t_idle;
        t_b2b;
        end_of_test;
    end
endmodule
`default_nettype wire
